// File: core/i2is_pkg.sv
package i2is_pkg;

  // Register addresses
  localparam logic [31:0] A_STATUS    = 32'h5000_152C;
  localparam logic [31:0] A_MASK      = 32'h5000_1530;
  localparam logic [31:0] A_RAW       = 32'h5000_1534;
  localparam logic [31:0] A_DATA_CMD  = 32'h5000_1510;
  localparam logic [31:0] A_RX_THR    = 32'h5000_1538;
  localparam logic [31:0] A_TX_TL     = 32'h5000_153C;
  localparam logic [31:0] A_CLR_ALL   = 32'h5000_1540;
  localparam logic [31:0] A_CLR_RDREQ = 32'h5000_1550;
  localparam logic [31:0] A_CLR_ABORT = 32'h5000_1554;
  localparam logic [31:0] A_CLR_ACT   = 32'h5000_155C;
  localparam logic [31:0] A_CLR_GC    = 32'h5000_1568;
  localparam logic [31:0] A_ENABLE    = 32'h5000_156C;

  // Flag positions in the status word
  localparam int B_GC   = 11;
  localparam int B_STA  = 10;
  localparam int B_STO  = 9;
  localparam int B_ACT  = 8;
  localparam int B_STXD = 7;
  localparam int B_ABT  = 6;
  localparam int B_RDR  = 5;
  localparam int B_TXL  = 4;
  localparam int B_TXO  = 3;
  localparam int B_RXH  = 2;
  localparam int B_RXO  = 1;
  localparam int B_RXU  = 0;

  // Reset values and sizes
  localparam logic [15:0] MASK_RST  = 16'h08FF;
  localparam logic [15:0] FLAGS_RST = 16'h0000;
  localparam logic [15:0] FLAG_USED = 16'h0FFF;
  localparam logic [7:0]  TL_RST    = 8'h00;
  localparam int          FIFO_AW   = 5;
  localparam int          FIFO_CW   = 6;
  localparam logic [5:0]  FIFO_FULL = 6'h20;
  localparam int          TX_W      = 9;
  localparam int          RX_W      = 8;

  // Register access request
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [31:0] addr;
    logic [31:0] wdata;
  } i2is_req_t;

  // Event strobes from the serial engine, link clock domain
  typedef struct packed {
    logic gen_call;
    logic start;
    logic stop;
    logic tx_nack;
    logic abort;
    logic rd_req;
    logic rx_byte;
    logic tx_pop;
  } i2is_lk_evt_t;

endpackage : i2is_pkg

// File: core/i2is_mem.sv
`timescale 1ns/10ps
module i2is_mem #(
  parameter int W  = 8,
  parameter int AW = 5
) (
  input  wire logic          clk,      // System clock
  input  wire logic          rst_b,    // Synchronous reset, active low
  input  wire logic          ce,       // Clock enable
  input  wire logic          we,       // Write strobe
  input  wire logic [AW-1:0] waddr,    // Write address
  input  wire logic [W-1:0]  wdata,    // Write data
  input  wire logic [AW-1:0] raddr,    // Read address
  output logic      [W-1:0]  rdata_q   // Registered read data
);
  logic [W-1:0] mem [2**AW];

  // Storage array
  always_ff @(posedge clk) begin
    if (ce && we) begin
      mem[waddr] <= wdata;
    end
  end

  // Read data register
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rdata_q <= '0;
    end else if (ce) begin
      rdata_q <= mem[raddr];
    end
  end
endmodule : i2is_mem

// File: core/i2is_core.sv
// What this block does
// - General call flag; cleared by read or disable
// - Bytes after general call enter receive FIFO
// - Start flag on START or repeated START
// - Stop flag on STOP, either role
// - Activity flag sticky until its clear read or disable
// - Slave transmit done on master NACK
// - Transmit abort flag on abort event
// - Abort holds transmit FIFO flushed until cleared
// - Read request flag; hold clock low
// - Read request flag clears on its read
// - Transmit low while level at/below threshold
// - Disabled: transmit low follows engine activity
// - Transmit overflow on write when full
// - Receive high while level at/above threshold
// - Disable flushes receive FIFO, clears high
// - Receive overflow on byte when full
// - Full FIFO drops byte, keeps contents
// - Receive underflow on read when empty
// - Overflow/underflow kept until clear-all read or internal enable low
// - Status equals raw flags gated by mask
`timescale 1ns/10ps
module i2is_core (
  input  wire logic                   clk,          // System clock
  input  wire logic                   rst_b,        // Synchronous reset, active low
  input  wire logic                   ce,           // Clock enable
  input  wire i2is_pkg::i2is_req_t    reg_req,      // Register request
  output logic      [31:0]            reg_rdata_q,  // Register read data
  output logic                        reg_rvld_q,   // Read data valid
  output logic      [8:0]             tx_head,      // Head of transmit FIFO
  output logic                        tx_avail_q,   // Transmit FIFO not empty
  output logic                        int_en_q,     // Internal enable
  input  wire logic                   lk_clk,       // Link clock
  input  wire logic                   lk_rst_b,     // Link reset, active low
  input  wire i2is_pkg::i2is_lk_evt_t lk_evt,       // Link event strobes
  input  wire logic [7:0]             lk_rx_data,   // Received byte
  input  wire logic                   lk_busy,      // Engine not idle
  output logic                        lk_scl_hold_q // Hold clock line low
);
  import i2is_pkg::*;

  logic [7:0]      lk_tgl_q;
  logic [7:0]      lk_rxd_q;
  logic            lk_hold_s1_q;
  logic [7:0]      ev_s1_q;
  logic [7:0]      ev_s2_q;
  logic [7:0]      ev_s3_q;
  logic            busy_s1_q;
  logic            busy_q;
  i2is_lk_evt_t    ev;
  logic [15:0]     raw_q;
  logic [15:0]     mask_q;
  logic            ctl_en_q;
  logic [7:0]      tx_tl_q;
  logic [7:0]      rx_thr_q;
  logic [FIFO_CW-1:0] tx_cnt_q;
  logic [FIFO_AW-1:0] tx_wp_q;
  logic [FIFO_AW-1:0] tx_rp_q;
  logic [FIFO_CW-1:0] rx_cnt_q;
  logic [FIFO_AW-1:0] rx_wp_q;
  logic [FIFO_AW-1:0] rx_rp_q;
  logic [7:0]      rx_head;
  logic            clr_all;
  logic            clr_gc;
  logic            clr_act;
  logic            clr_abt;
  logic            clr_rdr;
  logic            dc_wr;
  logic            dc_rd;
  logic            tx_push;
  logic            tx_pop;
  logic            rx_push;
  logic            rx_pop;
  logic [31:0]     rd_mux;

  // Decode a register access of one kind at one address
  function automatic logic hit(input i2is_req_t r, input logic kind, input logic [31:0] a);
    hit = kind && (r.addr == a);
  endfunction : hit

  // Link side: each event flips a toggle, byte held with it
  always_ff @(posedge lk_clk) begin
    if (!lk_rst_b) begin
      lk_tgl_q <= 8'h00;
      lk_rxd_q <= 8'h00;
    end else begin
      lk_tgl_q <= lk_tgl_q ^ lk_evt;
      if (lk_evt.rx_byte) begin
        lk_rxd_q <= lk_rx_data;
      end
    end
  end

  // Link side: clock stretch while read request pending
  // stretch clock line
  always_ff @(posedge lk_clk) begin
    if (!lk_rst_b) begin
      lk_hold_s1_q  <= 1'b0;
      lk_scl_hold_q <= 1'b0;
    end else begin
      lk_hold_s1_q  <= raw_q[B_RDR];
      lk_scl_hold_q <= lk_hold_s1_q;
    end
  end

  // Synchronise toggles and busy level into system clock
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ev_s1_q   <= 8'h00;
      ev_s2_q   <= 8'h00;
      ev_s3_q   <= 8'h00;
      busy_s1_q <= 1'b0;
      busy_q    <= 1'b0;
    end else if (ce) begin
      ev_s1_q   <= lk_tgl_q;
      ev_s2_q   <= ev_s1_q;
      ev_s3_q   <= ev_s2_q;
      busy_s1_q <= lk_busy;
      busy_q    <= busy_s1_q;
    end
  end

  // Decoded strobes
  assign ev      = ev_s2_q ^ ev_s3_q;
  assign clr_all = hit(reg_req, reg_req.rd, A_CLR_ALL);
  assign clr_gc  = hit(reg_req, reg_req.rd, A_CLR_GC) || clr_all;
  assign clr_act = hit(reg_req, reg_req.rd, A_CLR_ACT) || clr_all;
  assign clr_abt = hit(reg_req, reg_req.rd, A_CLR_ABORT) || clr_all;
  assign clr_rdr = hit(reg_req, reg_req.rd, A_CLR_RDREQ) || clr_all;
  assign dc_wr   = hit(reg_req, reg_req.wr, A_DATA_CMD);
  assign dc_rd   = hit(reg_req, reg_req.rd, A_DATA_CMD);
  assign tx_push = dc_wr && ctl_en_q && !raw_q[B_ABT] && (tx_cnt_q != FIFO_FULL);
  assign tx_pop  = ev.tx_pop && (tx_cnt_q != '0);
  assign rx_push = ev.rx_byte && ctl_en_q && (rx_cnt_q != FIFO_FULL);
  assign rx_pop  = dc_rd && (rx_cnt_q != '0);

  // Control registers written by software
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      mask_q   <= MASK_RST;
      ctl_en_q <= 1'b0;
      tx_tl_q  <= TL_RST;
      rx_thr_q <= TL_RST;
    end else if (ce && reg_req.wr) begin
      if (hit(reg_req, 1'b1, A_MASK)) begin
        mask_q <= reg_req.wdata[15:0] & FLAG_USED;
      end
      if (hit(reg_req, 1'b1, A_ENABLE)) begin
        ctl_en_q <= reg_req.wdata[0];
      end
      if (hit(reg_req, 1'b1, A_TX_TL)) begin
        tx_tl_q <= reg_req.wdata[7:0];
      end
      if (hit(reg_req, 1'b1, A_RX_THR)) begin
        rx_thr_q <= reg_req.wdata[7:0];
      end
    end
  end

  // Internal enable drops once disabled and engine idle
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      int_en_q <= 1'b0;
    end else if (ce) begin
      int_en_q <= ctl_en_q || (int_en_q && busy_q);
    end
  end

  // Transmit FIFO pointers
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      tx_cnt_q   <= '0;
      tx_wp_q    <= '0;
      tx_rp_q    <= '0;
      tx_avail_q <= 1'b0;
    end else if (ce) begin
      if (raw_q[B_ABT] || !ctl_en_q) begin
        tx_cnt_q   <= '0;
        tx_wp_q    <= '0;
        tx_rp_q    <= '0;
        tx_avail_q <= 1'b0;
      end else begin
        if (tx_push) begin
          tx_wp_q <= tx_wp_q + 1'b1;
        end
        if (tx_pop) begin
          tx_rp_q <= tx_rp_q + 1'b1;
        end
        tx_cnt_q   <= tx_cnt_q + FIFO_CW'(tx_push) - FIFO_CW'(tx_pop);
        tx_avail_q <= (tx_cnt_q + FIFO_CW'(tx_push) - FIFO_CW'(tx_pop)) != '0;
      end
    end
  end

  // Receive FIFO pointers
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rx_cnt_q <= '0;
      rx_wp_q  <= '0;
      rx_rp_q  <= '0;
    end else if (ce) begin
      if (!ctl_en_q) begin
        rx_cnt_q <= '0;
        rx_wp_q  <= '0;
        rx_rp_q  <= '0;
      end else begin
        if (rx_push) begin
          rx_wp_q <= rx_wp_q + 1'b1;
        end
        if (rx_pop) begin
          rx_rp_q <= rx_rp_q + 1'b1;
        end
        rx_cnt_q <= rx_cnt_q + FIFO_CW'(rx_push) - FIFO_CW'(rx_pop);
      end
    end
  end

  i2is_mem #(.W(TX_W), .AW(FIFO_AW)) u_tx_mem (
    .clk     (clk),
    .rst_b   (rst_b),
    .ce      (ce),
    .we      (tx_push),
    .waddr   (tx_wp_q),
    .wdata   (reg_req.wdata[8:0]),
    .raddr   (tx_rp_q),
    .rdata_q (tx_head)
  );

  i2is_mem #(.W(RX_W), .AW(FIFO_AW)) u_rx_mem (
    .clk     (clk),
    .rst_b   (rst_b),
    .ce      (ce),
    .we      (rx_push),
    .waddr   (rx_wp_q),
    .wdata   (lk_rxd_q),
    .raddr   (rx_rp_q),
    .rdata_q (rx_head)
  );

  // Raw event flags; a set beats a clear in the same cycle
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      raw_q <= FLAGS_RST;
    end else if (ce) begin
      if (ev.gen_call && ctl_en_q) raw_q[B_GC] <= 1'b1;
      else if (clr_gc || !ctl_en_q) raw_q[B_GC] <= 1'b0;
      if (ev.start) raw_q[B_STA] <= 1'b1;
      else if (clr_all) raw_q[B_STA] <= 1'b0;
      if (ev.stop) raw_q[B_STO] <= 1'b1;
      else if (clr_all) raw_q[B_STO] <= 1'b0;
      if (busy_q && ctl_en_q) raw_q[B_ACT] <= 1'b1;
      else if (clr_act || !ctl_en_q) raw_q[B_ACT] <= 1'b0;
      if (ev.tx_nack) raw_q[B_STXD] <= 1'b1;
      else if (clr_all) raw_q[B_STXD] <= 1'b0;
      if (ev.abort) raw_q[B_ABT] <= 1'b1;
      else if (clr_abt) raw_q[B_ABT] <= 1'b0;
      if (ev.rd_req) raw_q[B_RDR] <= 1'b1;
      else if (clr_rdr) raw_q[B_RDR] <= 1'b0;
      raw_q[B_TXL] <= ctl_en_q ? ({2'b00, tx_cnt_q} <= tx_tl_q) : busy_q;
      if (dc_wr && (tx_cnt_q == FIFO_FULL)) raw_q[B_TXO] <= 1'b1;
      else if (clr_all || !int_en_q) raw_q[B_TXO] <= 1'b0;
      raw_q[B_RXH] <= ctl_en_q && ({2'b00, rx_cnt_q} >= rx_thr_q);
      if (ev.rx_byte && ctl_en_q && (rx_cnt_q == FIFO_FULL)) raw_q[B_RXO] <= 1'b1;
      else if (clr_all || !int_en_q) raw_q[B_RXO] <= 1'b0;
      if (dc_rd && (rx_cnt_q == '0)) raw_q[B_RXU] <= 1'b1;
      else if (clr_all || !int_en_q) raw_q[B_RXU] <= 1'b0;
      raw_q[15:12] <= 4'h0;
    end
  end

  // Read data selection
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (reg_req.addr)
      A_STATUS:   rd_mux = {16'h0000, raw_q & mask_q & FLAG_USED};
      A_MASK:     rd_mux = {16'h0000, mask_q};
      A_RAW:      rd_mux = {16'h0000, raw_q & FLAG_USED};
      A_DATA_CMD: rd_mux = {24'h00_0000, rx_head};
      A_RX_THR:   rd_mux = {24'h00_0000, rx_thr_q};
      A_TX_TL:    rd_mux = {24'h00_0000, tx_tl_q};
      A_ENABLE:   rd_mux = {31'h0000_0000, ctl_en_q};
      default:    rd_mux = 32'h0000_0000;
    endcase
  end

  // Registered read answer
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      reg_rdata_q <= 32'h0000_0000;
      reg_rvld_q  <= 1'b0;
    end else if (ce) begin
      reg_rvld_q <= reg_req.rd;
      if (reg_req.rd) begin
        reg_rdata_q <= rd_mux;
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  AST_GC_CLEAR: assert property (
    (ce && clr_gc && !ev.gen_call) |=> !raw_q[B_GC])
    else $error("general call flag not cleared");

  AST_ACT_STICKY: assert property (
    (ce && raw_q[B_ACT] && !clr_act && ctl_en_q) |=> raw_q[B_ACT])
    else $error("activity flag lost");

  AST_ABORT_FLUSH: assert property (
    (ce && raw_q[B_ABT]) |=> (tx_cnt_q == '0) && !tx_avail_q)
    else $error("transmit FIFO not flushed on abort");

  AST_RDREQ_CLR: assert property (
    (ce && clr_rdr && !ev.rd_req) |=> !raw_q[B_RDR])
    else $error("read request not cleared");

  AST_TXO_SET: assert property (
    (ce && dc_wr && tx_cnt_q == FIFO_FULL) |=> raw_q[B_TXO])
    else $error("transmit overflow missed");

  AST_RXH_DIS: assert property (
    (ce && !ctl_en_q) |=> !raw_q[B_RXH] && (rx_cnt_q == '0))
    else $error("receive side not cleared on disable");

  AST_RX_KEEP: assert property (
    (ce && ev.rx_byte && !rx_pop && ctl_en_q && rx_cnt_q == FIFO_FULL)
      |=> (rx_cnt_q == FIFO_FULL) && raw_q[B_RXO] && $stable(rx_wp_q))
    else $error("full receive FIFO changed");

  AST_RXU_SET: assert property (
    (ce && dc_rd && rx_cnt_q == '0) |=> raw_q[B_RXU])
    else $error("receive underflow missed");

  AST_OVR_HOLD: assert property (
    (ce && raw_q[B_RXO] && int_en_q && !clr_all) |=> raw_q[B_RXO])
    else $error("overflow dropped while enabled");

  AST_STATUS_VIEW: assert property (
    (ce && hit(reg_req, reg_req.rd, A_STATUS))
      |=> reg_rvld_q && reg_rdata_q == {16'h0000, $past(raw_q) & $past(mask_q) & FLAG_USED})
    else $error("status read mismatch");
endmodule : i2is_core

// File: sim/i2is_engine_model.sv
`timescale 1ns/10ps
// Behavioural serial engine on the link side of the status block
module i2is_engine_model (
  input  wire logic            lk_clk,     // Link clock
  output i2is_pkg::i2is_lk_evt_t lk_evt,   // Event strobes
  output logic [7:0]           lk_rx_data, // Received byte
  output logic                 lk_busy     // Engine not idle
);
  import i2is_pkg::*;

  // Quiet engine at time zero
  initial begin
    lk_evt = '0;
    lk_rx_data = 8'h00;
    lk_busy = 1'b0;
  end

  // One strobe for one link cycle; the gap keeps same-kind events apart
  task automatic send_evt(input logic [7:0] ev, input logic [7:0] d);
    @(posedge lk_clk);
    lk_evt <= i2is_lk_evt_t'(ev);
    if (ev[1]) begin
      lk_rx_data <= d;
    end
    @(posedge lk_clk);
    lk_evt <= '0;
    repeat (5) @(posedge lk_clk);
  endtask : send_evt

  // Engine activity level, changed on a link edge
  task automatic set_busy(input logic b);
    @(posedge lk_clk);
    lk_busy <= b;
  endtask : set_busy
endmodule : i2is_engine_model

// File: sim/i2is_core_test.sv
`timescale 1ns/10ps
module i2is_core_test;
  import i2is_pkg::*;
  logic         clk, rst_b, ce, lk_clk, lk_rst_b;
  i2is_req_t    req;
  logic [31:0]  rdata;
  logic         rvld, tx_avail, int_en, scl_hold, lk_busy;
  logic [8:0]   tx_head;
  i2is_lk_evt_t lk_evt;
  logic [7:0]   lk_rx_data;
  int           miscompares, samples_checked;
  logic [15:0]  rd_v, exp;
  logic [7:0]   ev_tab [4] = '{8'h80, 8'h40, 8'h20, 8'h10};
  int           bit_tab [4] = '{B_GC, B_STA, B_STO, B_STXD};

  // System clock, 100 ns
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Link clock, 80 ns, offset in phase
  initial begin
    lk_clk = 1'b0;
    #13;
    forever #40 lk_clk = ~lk_clk;
  end

  i2is_core dut_u (
    .clk          (clk),
    .rst_b        (rst_b),
    .ce           (ce),
    .reg_req      (req),
    .reg_rdata_q  (rdata),
    .reg_rvld_q   (rvld),
    .tx_head      (tx_head),
    .tx_avail_q   (tx_avail),
    .int_en_q     (int_en),
    .lk_clk       (lk_clk),
    .lk_rst_b     (lk_rst_b),
    .lk_evt       (lk_evt),
    .lk_rx_data   (lk_rx_data),
    .lk_busy      (lk_busy),
    .lk_scl_hold_q(scl_hold)
  );

  i2is_engine_model eng_u (
    .lk_clk    (lk_clk),
    .lk_evt    (lk_evt),
    .lk_rx_data(lk_rx_data),
    .lk_busy   (lk_busy)
  );

  task automatic chk_word(input logic [15:0] got, input logic [15:0] want);
    samples_checked++;
    if (got !== want) begin
      miscompares++;
      $display("Error at %0t: word %h, expected %h", $time, got, want);
    end
  endtask : chk_word

  task automatic chk_bit(input logic got, input logic want);
    samples_checked++;
    if (got !== want) begin
      miscompares++;
      $display("Error at %0t: bit %b, expected %b", $time, got, want);
    end
  endtask : chk_bit

  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk);
  endtask : wait_clk

  task automatic reg_wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    req <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
    @(posedge clk);
    req.wr <= 1'b0;
  endtask : reg_wr

  // Idle gap first so earlier effects have landed in the flags
  task automatic reg_rd(input logic [31:0] a);
    wait_clk(2);
    req <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 32'h0000_0000};
    @(posedge clk);
    req.rd <= 1'b0;
    @(negedge clk);
    chk_bit(rvld, 1'b1);
    rd_v = rdata[15:0];
    chk_word(rdata[31:16], 16'h0000);
  endtask : reg_rd

  task automatic rd_chk(input logic [31:0] a, input logic [15:0] want);
    reg_rd(a);
    chk_word(rd_v, want);
  endtask : rd_chk

  task automatic rd_byte(input logic [7:0] want);
    reg_rd(A_DATA_CMD);
    chk_word({8'h00, rd_v[7:0]}, {8'h00, want});
  endtask : rd_byte

  task automatic evt(input logic [7:0] ev, input logic [7:0] d);
    eng_u.send_evt(ev, d);
    wait_clk(4);
  endtask : evt

  task automatic close_out;
    $display("checked %0d, mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : close_out

  // Watchdog, well beyond the expected run length
  initial begin
    #2_000_000;
    miscompares++;
    close_out();
  end

  // Main sequence
  initial begin
    rst_b = 1'b0;
    lk_rst_b = 1'b0;
    ce = 1'b1;
    req = '0;
    miscompares = 0;
    samples_checked = 0;
    wait_clk(12);
    rst_b <= 1'b1;
    lk_rst_b <= 1'b1;
    rd_chk(A_RAW, 16'h0000);
    rd_chk(A_MASK, MASK_RST);
    reg_wr(A_STATUS, 32'h0000_FFFF);
    rd_chk(A_STATUS, 16'h0000);
    rd_chk(32'h5000_1600, 16'h0000);
    reg_wr(A_RX_THR, 32'h0000_0002);
    reg_wr(A_MASK, 32'h0000_0FFF);
    reg_wr(A_ENABLE, 32'h0000_0001);
    eng_u.set_busy(1'b1);
    wait_clk(6);
    exp = 16'h0110;
    rd_chk(A_RAW, exp);
    // Each bus event sets its own flag
    for (int i = 0; i < 4; i++) begin
      evt(ev_tab[i], 8'h00);
      exp[bit_tab[i]] = 1'b1;
      rd_chk(A_RAW, exp);
    end
    eng_u.set_busy(1'b0);
    wait_clk(6);
    rd_chk(A_RAW, exp);
    reg_wr(A_MASK, {16'h0000, MASK_RST});
    rd_chk(A_STATUS, exp & MASK_RST);
    // Writes to the flag views must not disturb them
    reg_wr(A_STATUS, 32'h0000_0000);
    reg_wr(A_RAW, 32'h0000_0000);
    rd_chk(A_STATUS, exp & MASK_RST);
    reg_wr(A_MASK, 32'h0000_0FFF);
    evt(8'h04, 8'h00);
    exp[B_RDR] = 1'b1;
    rd_chk(A_RAW, exp);
    chk_bit(scl_hold, 1'b1);
    reg_wr(A_DATA_CMD, 32'h0000_01A5);
    reg_rd(A_CLR_RDREQ);
    exp[B_RDR] = 1'b0;
    exp[B_TXL] = 1'b0;
    rd_chk(A_RAW, exp);
    chk_bit(scl_hold, 1'b0);
    chk_word({7'h00, tx_head}, 16'h01A5);
    reg_rd(A_CLR_GC);
    exp[B_GC] = 1'b0;
    rd_chk(A_RAW, exp);
    reg_rd(A_CLR_ACT);
    exp[B_ACT] = 1'b0;
    rd_chk(A_RAW, exp);
    reg_rd(A_CLR_ALL);
    rd_chk(A_RAW, 16'h0000);
    // Fill the transmit queue to 32, then one write too many
    for (int i = 1; i < 32; i++) begin
      reg_wr(A_DATA_CMD, 32'(i));
    end
    rd_chk(A_RAW, 16'h0000);
    reg_wr(A_DATA_CMD, 32'h0000_0055);
    rd_chk(A_RAW, 16'h0008);
    chk_word({7'h00, tx_head}, 16'h01A5);
    // Engine takes the head word, the next one moves up
    evt(8'h01, 8'h00);
    @(negedge clk);
    chk_word({7'h00, tx_head}, 16'h0001);
    evt(8'h08, 8'h00);
    rd_chk(A_RAW, 16'h0058);
    reg_wr(A_DATA_CMD, 32'h0000_0077);
    wait_clk(3);
    @(negedge clk);
    chk_bit(tx_avail, 1'b0);
    reg_rd(A_CLR_ABORT);
    reg_wr(A_DATA_CMD, 32'h0000_0077);
    rd_chk(A_RAW, 16'h0008);
    chk_bit(tx_avail, 1'b1);
    chk_word({7'h00, tx_head}, 16'h0077);
    // Receive path, threshold two
    evt(8'h02, 8'h11);
    evt(8'h02, 8'h22);
    rd_chk(A_RAW, 16'h000C);
    rd_byte(8'h11);
    rd_chk(A_RAW, 16'h0008);
    rd_byte(8'h22);
    reg_rd(A_DATA_CMD);
    rd_chk(A_RAW, 16'h0009);
    // One byte beyond a full receive queue
    for (int i = 0; i < 33; i++) begin
      evt(8'h02, 8'(i));
    end
    rd_chk(A_RAW, 16'h000F);
    rd_byte(8'h00);
    // Disable while the engine is still busy
    eng_u.set_busy(1'b1);
    wait_clk(6);
    reg_wr(A_ENABLE, 32'h0000_0000);
    rd_chk(A_RAW, 16'h001B);
    chk_bit(int_en, 1'b1);
    eng_u.set_busy(1'b0);
    wait_clk(8);
    rd_chk(A_RAW, 16'h0000);
    chk_bit(int_en, 1'b0);
    close_out();
  end
endmodule : i2is_core_test
